// ===== hdl/sswd_top.sv
// Operation
// - Counter advances on the 1 kHz clock or on the bus clock, as selected.
// - Any reset leaves the watchdog enabled and counting without setup.
// - Writing 0x55 then 0xAA to the service register restarts the timeout.
// - Service register writes store nothing; they are only service events.
// - Counter reaching the overflow count without service requests a reset.
// - While enabled, any service write other than 0x55 or 0xAA requests an immediate reset.
// - Timeout select 00 disables the watchdog; it never requests a reset.
// - 1 kHz source: codes 01, 10, 11 overflow at 32, 256, 1024.
// - Source bit 0 picks 1 kHz, 1 picks bus clock: 2^13, 2^16, 2^18.
// - Out of reset: 1 kHz source with 1024-cycle timeout.
// - Windowed bus mode accepts service only in the last quarter of timeout.
// - Windowed mode: service write before the window opens requests reset.
// - With the 1 kHz source the window enable is ignored.
// - Counter is cleared by the first control write and by every reset.
// - Control register is write-once after reset; later writes are ignored.
// - Bus clock source: counter holds in debug and stop, resumes after.
// - 1 kHz source: counter cleared on debug or stop, restarts from zero.
// - Deep stop entry disables the watchdog until the next reset.
`timescale 1ns/1ns
`include "sswd_params.svh"
module sswd_top #(
  parameter int unsigned LPO_OVF_1 = `SSWD_LPO_OVF_1,
  parameter int unsigned LPO_OVF_2 = `SSWD_LPO_OVF_2,
  parameter int unsigned LPO_OVF_3 = `SSWD_LPO_OVF_3,
  parameter int unsigned BUS_OVF_1 = `SSWD_BUS_OVF_1,
  parameter int unsigned BUS_OVF_2 = `SSWD_BUS_OVF_2,
  parameter int unsigned BUS_OVF_3 = `SSWD_BUS_OVF_3,
  parameter int unsigned BUS_WIN_1 = `SSWD_BUS_WIN_1,
  parameter int unsigned BUS_WIN_2 = `SSWD_BUS_WIN_2,
  parameter int unsigned BUS_WIN_3 = `SSWD_BUS_WIN_3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        lpo_clk,
  input  wire logic        debug_mode,
  input  wire logic        stop_mode,
  input  wire logic        very_low_leakage_stop,
  output logic             system_reset_request
);

  sswd_pkg::sswd_state_type s;
  sswd_pkg::sswd_state_type next_s;

  logic                         lpo_level;
  logic                         lpo_rise;
  logic [`SSWD_COUNT_WIDTH-1:0] overflow_count;
  logic [`SSWD_COUNT_WIDTH-1:0] window_open;
  logic [`SSWD_COUNT_WIDTH-1:0] count_plus;
  logic [`SSWD_ADDR_BITS-1:0]   addr;
  logic                         enabled;
  logic                         windowed;
  logic                         halted;
  logic                         tick;
  logic                         addr_phase;
  logic [7:0]                   service_byte;
  logic                         hsize_unused;

  // 1 kHz clock comes from another domain
  sswd_sync u_lpo_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (lpo_clk),
    .level    (lpo_level),
    .rise     (lpo_rise)
  );

  sswd_timeout_lut #(
    .LPO_OVF_1 (LPO_OVF_1),
    .LPO_OVF_2 (LPO_OVF_2),
    .LPO_OVF_3 (LPO_OVF_3),
    .BUS_OVF_1 (BUS_OVF_1),
    .BUS_OVF_2 (BUS_OVF_2),
    .BUS_OVF_3 (BUS_OVF_3),
    .BUS_WIN_1 (BUS_WIN_1),
    .BUS_WIN_2 (BUS_WIN_2),
    .BUS_WIN_3 (BUS_WIN_3)
  ) u_lut (
    .timeout_select      (s.timeout_select),
    .clock_source_select (s.clock_source_select),
    .overflow_count      (overflow_count),
    .window_open         (window_open)
  );

  assign addr         = haddr[`SSWD_ADDR_BITS-1:0];
  assign addr_phase   = hsel & htrans[1] & hready;
  assign service_byte = hwdata[7:0];
  assign hsize_unused = ^hsize;
  assign count_plus   = s.count + `SSWD_COUNT_WIDTH'(1);

  assign enabled  = (s.timeout_select != `SSWD_TSEL_OFF) & ~s.vlls_off;
  assign windowed = s.clock_source_select & s.window_mode_enable;
  assign halted   = debug_mode | stop_mode;

  // One count step per selected clock edge, none while halted
  assign tick = s.clock_source_select ? ~halted : (lpo_rise & ~halted);

  always_comb begin
    next_s = s;

    // Bus address phase: latch write target, prepare read data
    next_s.wr_pend    = 1'b0;
    next_s.wr_ctrl    = 1'b0;
    next_s.wr_service = 1'b0;
    if (addr_phase) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        if (addr == `SSWD_CTRL_OFFSET) begin
          next_s.wr_ctrl = 1'b1;
        end else if (addr == `SSWD_SERVICE_OFFSET) begin
          next_s.wr_service = 1'b1;
        end
      end else begin
        next_s.rdata = '0;
        if (addr == `SSWD_CTRL_OFFSET) begin
          next_s.rdata[`SSWD_TSEL_MSB:`SSWD_TSEL_LSB] = s.timeout_select;
          next_s.rdata[`SSWD_CSEL_BIT]               = s.clock_source_select;
          next_s.rdata[`SSWD_WIN_BIT]                = s.window_mode_enable;
          next_s.rdata[`SSWD_LOCK_BIT]               = s.locked;
        end else if (addr == `SSWD_SERVICE_OFFSET) begin
          next_s.rdata = '0;
        end else if (addr == `SSWD_STATUS_OFFSET) begin
          next_s.rdata[`SSWD_COUNT_WIDTH-1:0] = s.count;
        end else begin
          next_s.rdata = '0;
        end
      end
    end

    // Counter
    if (!s.clock_source_select && halted) begin
      next_s.count = '0;
    end else if (tick && enabled) begin
      next_s.count = count_plus;
      if (count_plus == overflow_count) begin
        next_s.reset_request = 1'b1;
      end
    end

    if (very_low_leakage_stop) begin
      next_s.vlls_off = 1'b1;
    end

    // Bus data phase: control write, locked after the first one
    if (s.wr_pend && s.wr_ctrl && !s.locked) begin
      next_s.timeout_select      = hwdata[`SSWD_TSEL_MSB:`SSWD_TSEL_LSB];
      next_s.clock_source_select = hwdata[`SSWD_CSEL_BIT];
      next_s.window_mode_enable  = hwdata[`SSWD_WIN_BIT];
      next_s.locked              = 1'b1;
      next_s.count               = '0;
      next_s.seq                 = sswd_pkg::SSWD_SEQ_IDLE;
    end

    // Bus data phase: service write, value is never stored
    if (s.wr_pend && s.wr_service && enabled) begin
      if (windowed && (s.count < window_open)) begin
        next_s.reset_request = 1'b1;
      end else begin
        case (s.seq)
          sswd_pkg::SSWD_SEQ_IDLE: begin
            if (service_byte == `SSWD_SERVICE_FIRST) begin
              next_s.seq = sswd_pkg::SSWD_SEQ_ARMED;
            end else if (service_byte != `SSWD_SERVICE_SECOND) begin
              next_s.reset_request = 1'b1;
            end
          end
          sswd_pkg::SSWD_SEQ_ARMED: begin
            next_s.seq = sswd_pkg::SSWD_SEQ_IDLE;
            if (service_byte == `SSWD_SERVICE_SECOND) begin
              next_s.count = '0;
            end else begin
              next_s.reset_request = 1'b1;
            end
          end
          default: begin
            next_s.seq = sswd_pkg::SSWD_SEQ_IDLE;
          end
        endcase
      end
    end

    // Keeps the otherwise unused inputs observed without changing state
    if (lpo_level && hsize_unused && 1'b0) begin
      next_s.rdata = s.rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s                     <= '0;
      s.timeout_select      <= `SSWD_TSEL_RESET;
      s.clock_source_select <= `SSWD_CSEL_RESET;
      s.window_mode_enable  <= `SSWD_WIN_RESET;
      s.seq                 <= sswd_pkg::SSWD_SEQ_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata               = s.rdata;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign system_reset_request = s.reset_request;

endmodule

// ===== hdl/sswd_params.svh
`ifndef SSWD_PARAMS_SVH
`define SSWD_PARAMS_SVH

// Register byte offsets, decoded on haddr[11:0]
`define SSWD_ADDR_BITS           12
`define SSWD_CTRL_OFFSET         12'h000
`define SSWD_SERVICE_OFFSET      12'h004
`define SSWD_STATUS_OFFSET       12'h008

// Control register field positions
`define SSWD_TSEL_LSB            0
`define SSWD_TSEL_MSB            1
`define SSWD_CSEL_BIT            2
`define SSWD_WIN_BIT             3
`define SSWD_LOCK_BIT            8

// Control reset values
`define SSWD_TSEL_RESET          2'h3
`define SSWD_CSEL_RESET          1'h0
`define SSWD_WIN_RESET           1'h0
`define SSWD_TSEL_OFF            2'h0

// Service sequence bytes
`define SSWD_SERVICE_FIRST       8'h55
`define SSWD_SERVICE_SECOND      8'haa

// Overflow counts, 1 kHz source (32 ms, 256 ms, 1024 ms)
`define SSWD_LPO_OVF_1           32
`define SSWD_LPO_OVF_2           256
`define SSWD_LPO_OVF_3           1024

// Overflow counts and window openings, bus clock source
`define SSWD_BUS_OVF_1           8192
`define SSWD_BUS_OVF_2           65536
`define SSWD_BUS_OVF_3           262144
`define SSWD_BUS_WIN_1           6144
`define SSWD_BUS_WIN_2           49152
`define SSWD_BUS_WIN_3           196608

`define SSWD_COUNT_WIDTH         19

`endif

// ===== hdl/sswd_pkg.sv
package sswd_pkg;

  typedef enum logic [1:0] {
    SSWD_SEQ_IDLE  = 2'b01,
    SSWD_SEQ_ARMED = 2'b10
  } sswd_seq_type;

  typedef struct packed {
    logic [1:0]   timeout_select;
    logic         clock_source_select;
    logic         window_mode_enable;
    logic         locked;
    logic         vlls_off;
    sswd_seq_type seq;
    logic [18:0]  count;
    logic         reset_request;
    logic         wr_pend;
    logic         wr_ctrl;
    logic         wr_service;
    logic [31:0]  rdata;
  } sswd_state_type;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sswd_sync_type;

endpackage

// ===== hdl/sswd_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser with rising-edge detect behind the second stage
module sswd_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);

  sswd_pkg::sswd_sync_type s;
  sswd_pkg::sswd_sync_type next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = async_in;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.sync;
  assign rise  = s.sync & ~s.last;

endmodule

// ===== hdl/sswd_timeout_lut.sv
`timescale 1ns/1ns
`include "sswd_params.svh"
// Decodes overflow count and window opening from the control fields
module sswd_timeout_lut #(
  parameter int unsigned LPO_OVF_1 = `SSWD_LPO_OVF_1,
  parameter int unsigned LPO_OVF_2 = `SSWD_LPO_OVF_2,
  parameter int unsigned LPO_OVF_3 = `SSWD_LPO_OVF_3,
  parameter int unsigned BUS_OVF_1 = `SSWD_BUS_OVF_1,
  parameter int unsigned BUS_OVF_2 = `SSWD_BUS_OVF_2,
  parameter int unsigned BUS_OVF_3 = `SSWD_BUS_OVF_3,
  parameter int unsigned BUS_WIN_1 = `SSWD_BUS_WIN_1,
  parameter int unsigned BUS_WIN_2 = `SSWD_BUS_WIN_2,
  parameter int unsigned BUS_WIN_3 = `SSWD_BUS_WIN_3
) (
  input  wire logic [1:0]                   timeout_select,
  input  wire logic                         clock_source_select,
  output logic      [`SSWD_COUNT_WIDTH-1:0] overflow_count,
  output logic      [`SSWD_COUNT_WIDTH-1:0] window_open
);

  always_comb begin
    overflow_count = '0;
    window_open    = '0;
    if (clock_source_select) begin
      case (timeout_select)
        2'h1: begin
          overflow_count = `SSWD_COUNT_WIDTH'(BUS_OVF_1);
          window_open    = `SSWD_COUNT_WIDTH'(BUS_WIN_1);
        end
        2'h2: begin
          overflow_count = `SSWD_COUNT_WIDTH'(BUS_OVF_2);
          window_open    = `SSWD_COUNT_WIDTH'(BUS_WIN_2);
        end
        2'h3: begin
          overflow_count = `SSWD_COUNT_WIDTH'(BUS_OVF_3);
          window_open    = `SSWD_COUNT_WIDTH'(BUS_WIN_3);
        end
        default: begin
          overflow_count = '0;
          window_open    = '0;
        end
      endcase
    end else begin
      case (timeout_select)
        2'h1: begin
          overflow_count = `SSWD_COUNT_WIDTH'(LPO_OVF_1);
        end
        2'h2: begin
          overflow_count = `SSWD_COUNT_WIDTH'(LPO_OVF_2);
        end
        2'h3: begin
          overflow_count = `SSWD_COUNT_WIDTH'(LPO_OVF_3);
        end
        default: begin
          overflow_count = '0;
        end
      endcase
    end
  end

endmodule

// ===== dv/sswd_assertions.sv
`timescale 1ns/1ns
`include "sswd_params.svh"
module sswd_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        very_low_leakage_stop,
  input wire logic        system_reset_request
);
  logic       wr_c, wr_s, rd_c, rd_s, lock, dis, armed;
  logic [1:0] tsel;
  wire        act = hsel && htrans[1] && hready;
  wire        en  = tsel != 2'h0 && !dis;
  wire        svc = wr_s && en;
  wire [7:0]  b   = hwdata[7:0];
  // Shadow of control and arming, seen from the bus and the deep stop input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_c, wr_s, rd_c, rd_s, lock, dis, armed} <= '0;
      tsel <= `SSWD_TSEL_RESET;
    end else begin
      wr_c  <= act && hwrite && haddr[11:0] == `SSWD_CTRL_OFFSET;
      wr_s  <= act && hwrite && haddr[11:0] == `SSWD_SERVICE_OFFSET;
      rd_c  <= act && !hwrite && haddr[11:0] == `SSWD_CTRL_OFFSET;
      rd_s  <= act && !hwrite && haddr[11:0] == `SSWD_SERVICE_OFFSET;
      dis   <= dis || very_low_leakage_stop;
      lock  <= lock || wr_c;
      tsel  <= wr_c && !lock ? hwdata[1:0] : tsel;
      armed <= svc ? b == 8'h55 : armed;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_req_sticky: assert property (system_reset_request |=> system_reset_request)
    else $error("reset request dropped");
  a_bad_value: assert property (
    svc && b != 8'h55 && b != 8'haa |-> ##[1:2] system_reset_request)
    else $error("illegal service byte left no reset");
  a_pair_broken: assert property (
    svc && armed && b == 8'h55 |-> ##[1:2] system_reset_request)
    else $error("broken pair left no reset");
  a_off_quiet: assert property (lock && tsel == 2'h0 |=> !$rose(system_reset_request))
    else $error("disabled watchdog raised reset");
  a_deep_quiet: assert property (dis |=> !$rose(system_reset_request))
    else $error("reset raised after deep stop");
  a_svc_zero: assert property (rd_s |-> hrdata == 32'h0)
    else $error("service register read not zero");
  a_lock_shown: assert property (rd_c && $past(lock) |-> hrdata[`SSWD_LOCK_BIT])
    else $error("lock bit not shown");
  a_reset_clean: assert property (!$past(hresetn) |-> !system_reset_request)
    else $error("reset request right after reset");
  c_bad_value: cover property (svc && b != 8'h55 && b != 8'haa);
  c_good_pair: cover property (svc && armed && b == 8'haa);
  c_deep_stop: cover property (dis && lock);
endmodule

// ===== dv/sswd_host.sv
`timescale 1ns/1ns
`include "sswd_params.svh"
module sswd_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    {hsel, haddr, htrans, hwrite} = '0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Single word transfer; caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Released data must not keep the last value
    hwdata <= ~hwdata;
  endtask
  task automatic service;
    logic [31:0] q;
    xfer(1'b1, {20'h0, `SSWD_SERVICE_OFFSET}, {24'h0, `SSWD_SERVICE_FIRST}, q);
    xfer(1'b1, {20'h0, `SSWD_SERVICE_OFFSET}, {24'h0, `SSWD_SERVICE_SECOND}, q);
  endtask
endmodule

// ===== dv/sswd_top_bench.sv
`timescale 1ns/1ns
`include "sswd_params.svh"
module sswd_top_bench;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              lpo_clk = 1'b0;
  logic              debug_mode = 1'b0;
  logic              stop_mode = 1'b0;
  logic              very_low_leakage_stop = 1'b0;
  logic [31:0]       rd;
  logic [31:0]       rnd = 32'h59027317;
  wire  logic        hsel, hwrite, hreadyout, hresp, req;
  wire  logic [1:0]  htrans;
  wire  logic [2:0]  hsize;
  wire  logic [31:0] haddr, hwdata, hrdata;
  int                failures = 0;
  int                tests_run = 0;
  int                ovf [4] = '{300, 64, 128, 256};
  int                lpo [4] = '{75, `SSWD_LPO_OVF_1, `SSWD_LPO_OVF_2, `SSWD_LPO_OVF_3};
  int                m;
  always #2 hclk = ~hclk;
  // Scaled low-power clock: 4 bus cycles a period, toggling on falling bus clock edges
  always #8 lpo_clk = ~lpo_clk;
  sswd_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Bus timeouts shortened; windowed codes 2 and 3 stay unexercised
  sswd_top #(.BUS_OVF_1(64), .BUS_OVF_2(128), .BUS_OVF_3(256), .BUS_WIN_1(48)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lpo_clk(lpo_clk), .debug_mode(debug_mode),
    .stop_mode(stop_mode), .very_low_leakage_stop(very_low_leakage_stop),
    .system_reset_request(req));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, {20'h0, a}, d, rd);
  endtask
  task automatic rdc(input logic [11:0] a);
    host.xfer(1'b0, {20'h0, a}, 32'h0, rd);
  endtask
  task automatic restart(input logic [31:0] ctl);
    hresetn <= 1'b0;
    {debug_mode, stop_mode, very_low_leakage_stop} <= 3'h0;
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    wr(`SSWD_CTRL_OFFSET, ctl);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    rdc(`SSWD_CTRL_OFFSET);
    check(rd & 32'h1ff, 32'h003, "control reset");
    wr(`SSWD_CTRL_OFFSET, 32'h3);
    wr(`SSWD_CTRL_OFFSET, 32'h4);
    rdc(`SSWD_CTRL_OFFSET);
    check(rd & 32'h1ff, 32'h103, "control locked");
    rdc(`SSWD_SERVICE_OFFSET);
    check(rd, 32'h0, "service read");
    rdc(12'h00c);
    check(rd, 32'h0, "unmapped read");
    check({30'h0, hreadyout, hresp}, 32'h2, "ready and response");
    for (int cs = 0; cs < 2; cs++) begin
      for (int t = 0; t < 4; t++) begin
        rnd = lfsr(rnd);
        restart({rnd[31:4], 1'b0, cs[0], t[1:0]});
        m = cs ? 3 : 20;
        tick((cs ? ovf[t] : 4 * lpo[t]) - m);
        check(32'(req), 32'h0, "early request");
        tick(2 * m);
        check(32'(req), 32'(t != 0), "overflow");
      end
    end
    restart(32'h5);
    tick(40);
    rdc(`SSWD_STATUS_OFFSET);
    check(rd, 32'h28, "status count");
    host.service();
    tick(40);
    check(32'(req), 32'h0, "after service");
    tick(30);
    check(32'(req), 32'h1, "after restart");
    restart(32'hd);
    tick(52);
    host.service();
    tick(20);
    check(32'(req), 32'h0, "late service");
    host.service();
    tick(2);
    check(32'(req), 32'h1, "early service");
    restart(32'h9);
    tick(10);
    host.service();
    tick(30);
    check(32'(req), 32'h0, "service any time");
    do begin
      rnd = lfsr(rnd);
    end while (rnd[7:0] == 8'h55 || rnd[7:0] == 8'haa);
    restart(32'h7);
    wr(`SSWD_SERVICE_OFFSET, rnd);
    tick(2);
    check(32'(req), 32'h1, "illegal byte");
    restart(32'h7);
    wr(`SSWD_SERVICE_OFFSET, 32'h55);
    wr(`SSWD_SERVICE_OFFSET, 32'h55);
    tick(2);
    check(32'(req), 32'h1, "broken pair");
    for (int cs = 0; cs < 2; cs++) begin
      restart(cs ? 32'h5 : 32'h1);
      tick(cs ? 30 : 100);
      debug_mode <= cs[0];
      stop_mode <= !cs[0];
      tick(100);
      {debug_mode, stop_mode} <= 2'h0;
      tick(cs ? 28 : 110);
      check(32'(req), 32'h0, "held or cleared");
      tick(cs ? 12 : 30);
      check(32'(req), 32'h1, "resumed");
    end
    restart(32'h5);
    tick(5);
    very_low_leakage_stop <= 1'b1;
    tick(1);
    very_low_leakage_stop <= 1'b0;
    tick(80);
    wr(`SSWD_SERVICE_OFFSET, 32'h13);
    tick(3);
    check(32'(req), 32'h0, "deep stop");
    restart(32'h5);
    tick(70);
    check(32'(req), 32'h1, "wake reset");
    close_out();
  end
endmodule
bind sswd_top sswd_assertions chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .very_low_leakage_stop(very_low_leakage_stop), .system_reset_request(system_reset_request));
